// [src/asp_pkg.sv]
// Constants for the sample output pipeline
`default_nettype none
package asp_pkg;
	localparam int          DATA_W       = 10;
	localparam int          LAT_CYC      = 7;
	localparam int          INIT_CYC     = 20;
	localparam logic [4:0]  INIT_CNT_MAX = 5'h14;
	localparam int          MSB_POS      = 9;
	localparam int          SYNC_DEPTH   = 3;
	localparam int          BUF_DEPTH    = 2;
	localparam logic [9:0]  DATA_RST     = 10'h000;
endpackage
`default_nettype wire

// [src/asp_top.sv]
// Digital side of a 10-bit pipelined sampling converter
//
// Functional notes
// - A sample is taken on each falling edge of the sample clock.
// - The word for a sample appears on the data bus in the seventh sample clock cycle after it.
// - After power-up each following sample gives one new word per sample clock cycle while the output buffer has room.
// - With format select low the word is offset binary.
// - With format select high the word is two's complement.
// - The word is ten bits D9 down to D0; two's complement is offset binary with the MSB inverted.
`default_nettype none
module asp_top (
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic        i_smp_clk,
	input  wire logic [9:0]  i_ain_code,
	input  wire logic        i_output_format_select,
	input  wire logic        i_out_ready,
	output var  logic [9:0]  o_data,
	output var  logic        o_data_valid,
	output var  logic        o_init_done
);
	////////////////////////////////////////////////////////////////
	// All state of the block
	typedef struct packed {
		logic [asp_pkg::SYNC_DEPTH-1:0]                     clk_sync;
		logic                                               clk_level;
		logic [asp_pkg::SYNC_DEPTH-1:0]                     fmt_sync;
		logic                                               fmt_level;
		logic [asp_pkg::LAT_CYC-2:0][asp_pkg::DATA_W-1:0]   pipe;
		logic [4:0]                                         init_cnt;
		logic [asp_pkg::BUF_DEPTH-1:0][asp_pkg::DATA_W-1:0] buf_data;
		logic [1:0]                                         buf_cnt;
		logic [asp_pkg::DATA_W-1:0]                         data;
		logic                                               valid;
		logic                                               init_done;
	} asp_state_s;

	asp_state_s                                         state_ff;
	asp_state_s                                         nxt_state;

	logic [asp_pkg::SYNC_DEPTH-1:0]                     clk_shift;
	logic [asp_pkg::SYNC_DEPTH-1:0]                     fmt_shift;
	logic                                               clk_now;
	logic                                               clk_agree;
	logic                                               fmt_now;
	logic                                               fmt_agree;
	logic                                               smp_fall;
	logic                                               fmt_sel;

	logic [asp_pkg::LAT_CYC-2:0][asp_pkg::DATA_W-1:0]   pipe_shift;
	logic [asp_pkg::DATA_W-1:0]                         out_word;
	logic [asp_pkg::DATA_W-1:0]                         coded;

	logic                                               init_reached;
	logic [4:0]                                         init_cnt_inc;

	logic [1:0]                                         buf_full_cnt;
	logic                                               buf_not_full;
	logic                                               in_ready;
	logic                                               push;
	logic                                               pop;
	logic [1:0]                                         cnt_after_pop;
	logic [1:0]                                         cnt_after_push;
	logic                                               wr_idx;
	logic [asp_pkg::BUF_DEPTH-1:0][asp_pkg::DATA_W-1:0] buf_next;

	genvar g;

	////////////////////////////////////////////////////////////////
	// Three-stage synchronisers on the pins
	generate
		for (g = 0; g < asp_pkg::SYNC_DEPTH; g = g + 1) begin : g_sync
			if (g == 0) begin : g_first
				assign clk_shift[g] = i_smp_clk;
				assign fmt_shift[g] = i_output_format_select;
			end else begin : g_next
				assign clk_shift[g] = state_ff.clk_sync[g-1];
				assign fmt_shift[g] = state_ff.fmt_sync[g-1];
			end
		end
	endgenerate

	// A level counts only once stages two and three agree
	assign clk_now   = state_ff.clk_sync[asp_pkg::SYNC_DEPTH-1];
	assign clk_agree = (state_ff.clk_sync[asp_pkg::SYNC_DEPTH-2] == clk_now);
	assign fmt_now   = state_ff.fmt_sync[asp_pkg::SYNC_DEPTH-1];
	assign fmt_agree = (state_ff.fmt_sync[asp_pkg::SYNC_DEPTH-2] == fmt_now);

	// Settled high to settled low is one sample
	assign smp_fall  = clk_agree & ~clk_now & state_ff.clk_level;
	assign fmt_sel   = state_ff.fmt_level;

	////////////////////////////////////////////////////////////////
	// Latency line: capture stage plus the delay stages
	generate
		for (g = 0; g < asp_pkg::LAT_CYC - 1; g = g + 1) begin : g_pipe
			if (g == 0) begin : g_head
				assign pipe_shift[g] = i_ain_code;
			end else begin : g_tail
				assign pipe_shift[g] = state_ff.pipe[g-1];
			end
		end
	endgenerate

	assign out_word = state_ff.pipe[asp_pkg::LAT_CYC-2];

	// Format applied as the word leaves the line
	assign coded = {
		out_word[asp_pkg::MSB_POS] ^ fmt_sel,
		out_word[asp_pkg::MSB_POS-1:0]
	};

	////////////////////////////////////////////////////////////////
	// Power-up count of sample falls
	assign init_reached = (state_ff.init_cnt == asp_pkg::INIT_CNT_MAX);
	assign init_cnt_inc = state_ff.init_cnt + 5'h01;

	////////////////////////////////////////////////////////////////
	// Two-entry output buffer, head at index 0
	assign buf_full_cnt = 2'(asp_pkg::BUF_DEPTH);
	assign pop          = state_ff.valid & i_out_ready;
	assign buf_not_full = (state_ff.buf_cnt != buf_full_cnt);
	assign in_ready     = buf_not_full | pop;
	// Words before power-up is over are dropped
	assign push         = smp_fall & state_ff.init_done & in_ready;

	assign cnt_after_pop = pop ?
		(state_ff.buf_cnt - 2'h1) :
		state_ff.buf_cnt;

	assign cnt_after_push = push ?
		(cnt_after_pop + 2'h1) :
		cnt_after_pop;

	assign wr_idx = cnt_after_pop[0];

	generate
		for (g = 0; g < asp_pkg::BUF_DEPTH; g = g + 1) begin : g_buf
			logic [asp_pkg::DATA_W-1:0] kept;
			if (g < asp_pkg::BUF_DEPTH - 1) begin : g_shift
				assign kept = pop ? state_ff.buf_data[g+1] : state_ff.buf_data[g];
			end else begin : g_last
				assign kept = state_ff.buf_data[g];
			end
			assign buf_next[g] = (push && (wr_idx == 1'(g))) ? coded : kept;
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		nxt_state = state_ff;

		nxt_state.clk_sync = clk_shift;
		nxt_state.fmt_sync = fmt_shift;

		if (clk_agree) begin
			nxt_state.clk_level = clk_now;
		end else begin
			nxt_state.clk_level = state_ff.clk_level;
		end

		if (fmt_agree) begin
			nxt_state.fmt_level = fmt_now;
		end else begin
			nxt_state.fmt_level = state_ff.fmt_level;
		end

		if (smp_fall) begin
			nxt_state.pipe = pipe_shift;
		end else begin
			nxt_state.pipe = state_ff.pipe;
		end

		if (smp_fall && !init_reached) begin
			nxt_state.init_cnt = init_cnt_inc;
		end else begin
			nxt_state.init_cnt = state_ff.init_cnt;
		end

		nxt_state.init_done = init_reached;
		nxt_state.buf_data  = buf_next;
		nxt_state.buf_cnt   = cnt_after_push;
		nxt_state.valid     = (cnt_after_push != 2'h0);
		nxt_state.data      = buf_next[0];
	end

	////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	assign o_data       = state_ff.data;
	assign o_data_valid = state_ff.valid;
	assign o_init_done  = state_ff.init_done;

endmodule
`default_nettype wire

// [tb/asp_checker.sv]
// Port checker for the sample output pipeline
`default_nettype none
module asp_checker (
	input wire logic       i_mclk,
	input wire logic       i_rst,
	input wire logic       i_out_ready,
	input wire logic       o_data_valid,
	input wire logic       o_init_done,
	input wire logic [9:0] o_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] age_ff;
	// Cycles since reset, saturating
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			age_ff <= 8'h00;
		end else if (age_ff != 8'hFF) begin
			age_ff <= age_ff + 8'h01;
		end
	end
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);
	sequence word_offered;
		o_data_valid && !i_out_ready;
	endsequence
	sequence word_kept;
		o_data_valid && $stable(o_data);
	endsequence
	word_hold_a: assert property (word_offered |=> word_kept)
		else $error("stalled word changed");
	fill_gate_a: assert property (!o_init_done |-> !o_data_valid)
		else $error("word before init");
	init_hold_a: assert property (o_init_done |=> o_init_done)
		else $error("init flag dropped");
	reset_clear_a: assert property (disable iff (1'b0) i_rst |=> !o_data_valid && !o_init_done)
		else $error("outputs set in reset");
	init_wait_a: assert property ($rose(o_init_done) |-> age_ff >= 8'h28)
		else $error("init flag too early");
	data_quiet_a: assert property (!o_init_done |-> o_data == 10'h000)
		else $error("data before init");
endmodule
`default_nettype wire

// [tb/asp_host_model.sv]
// Host model: sample clock and consumer ready
`default_nettype none
module asp_host_model (input wire logic i_mclk, i_rnd, output wire logic o_smp_clk, o_ready);
	timeunit 1ns; timeprecision 1ns;
	logic [2:0] ph = 3'h0;
	always @(negedge i_mclk) ph <= ph + 3'h1;
	// Eight cycles a sample, half high
	assign o_smp_clk = !ph[2];
	assign o_ready = i_rnd;
endmodule
`default_nettype wire

// [tb/tb_adc_sample_output_pipeline.sv]
// Bench for the sample output pipeline
`default_nettype none
module tb_adc_sample_output_pipeline;
	timeunit 1ns; timeprecision 1ns;
	logic mclk = 0, rst = 1, fmt = 0, smp, rdy, vld, init;
	logic [9:0] code = 10'h000, dout, exp_q[$];
	logic [31:0] rnd = 32'h9335;
	int failures = 0, checks = 0, n = 0;
	always #50 mclk = ~mclk;
	// Stall falls on zero words only, so the full buffer may drop them
	asp_host_model u_host (.i_mclk(mclk), .i_rnd((rnd[0] | rnd[3]) && (n < 58 || n > 68)),
		.o_smp_clk(smp), .o_ready(rdy));
	asp_top u_dut (.i_mclk(mclk), .i_rst(rst), .i_smp_clk(smp), .i_ain_code(code),
		.i_output_format_select(fmt), .i_out_ready(rdy), .o_data(dout), .o_data_valid(vld),
		.o_init_done(init));
	function logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task check(logic [9:0] s, w);
		checks++;
		if (s !== w) begin
			failures++;
			$display("[FAIL] %0t word mismatch got %h want %h", $time, s, w);
		end
	endtask
	task test_done;
		$display("failures %0d checks %0d", failures, checks);
		if (failures == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Code changes on the rise, is taken on the fall
	always @(posedge smp) begin
		n++;
		code = (n % 60 > 24 && n % 60 < 50 && n < 120) ? {rnd[9:1], 1'b1} : 10'h000;
		if (code[0]) exp_q.push_back(code ^ {fmt, 9'h000});
		if (n == 72) fmt = 1;
	end
	always @(posedge mclk) if ((vld & rdy) === 1'b1 && dout[8:0] !== 9'h000)
		check(dout, exp_q.size() ? exp_q.pop_front() : ~dout);
	initial begin
		repeat (20) @(negedge mclk);
		rst = 0;
		for (int i = 0; i < 2000 && n < 140; i++) @(negedge mclk) rnd = lfsr(rnd);
		check({8'h00, init, exp_q.size() == 0 && n > 139}, 10'h003);
		test_done;
	end
endmodule
bind asp_top asp_checker u_chk (
	.i_mclk       (i_mclk),
	.i_rst        (i_rst),
	.i_out_ready  (i_out_ready),
	.o_data_valid (o_data_valid),
	.o_init_done  (o_init_done),
	.o_data       (o_data)
);
`default_nettype wire
